// ==== src/ncd_clock_divider.sv ====
// How it works
// - Bit 7 read-only flag sets on first divider write, any data.
// - System reset clears flag and every divider bit to zero.
// - Bits 6..0 always readable, written once after reset only.
// - Erase and program blocked while flag is 0, permitted once 1.
// - Prescale bit 6 picks bus clock or bus clock divided by 8.
// - Divider divides its input by divisor field plus one.
// - Each timing pulse lasts one bus clock cycle, one per memory clock period, except with prescale off and divisor 0, where it stays high.
// - Sequencer times each operation as whole number of pulses.
//
// Our own choices: the Wishbone slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none

module ncd_clock_divider (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        nrst,
    // Classic Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    // Sequencer side
    input  wire logic        pe_request,
    input  wire logic [15:0] pe_pulse_count,
    output logic             pe_enable,
    output logic             nvm_internal_clock,
    output logic             timing_pulse,
    output logic             pe_busy,
    output logic             pe_done
);

    logic [1:0] rst_sync_reg;
    logic       rst_n;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // Bus decode
    logic req;
    logic hit_ctrl;
    logic hit_state;
    logic ctrl_wr;
    assign req       = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    function automatic logic addr_hit(input logic [ncd_pkg::addr_w-1:0] a,
                                      input logic [ncd_pkg::addr_w-1:0] base);
        return (a == base);
    endfunction
    assign hit_ctrl  = addr_hit(wb_adr_i, ncd_pkg::ctrl_addr);
    assign hit_state = addr_hit(wb_adr_i, ncd_pkg::state_addr);
    assign ctrl_wr   = req && hit_ctrl && wb_we_i && wb_sel_i[0];

    // Divider register
    logic                      loaded_reg;
    logic                      prescale_reg;
    logic [ncd_pkg::div_w-1:0] divisor_reg;
    logic [7:0]                ctrl_view;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            loaded_reg   <= 1'b0;
            prescale_reg <= 1'b0;
            divisor_reg  <= '0;
        end else if (ctrl_wr && !loaded_reg) begin
            loaded_reg   <= 1'b1;
            prescale_reg <= wb_dat_i[ncd_pkg::prescale_bit];
            divisor_reg  <= wb_dat_i[ncd_pkg::div_w-1:0];
        end
    end
    assign ctrl_view = {loaded_reg, prescale_reg, divisor_reg};

    // Bus answer, one cycle after the request
    logic [31:0] rd_next;
    logic        ack_next;
    logic        err_next;
    assign ack_next = req && (hit_ctrl || hit_state);
    assign err_next = req && !(hit_ctrl || hit_state);
    assign rd_next  = hit_ctrl  ? {24'h00_0000, ctrl_view} :
                      hit_state ? {29'h0000_0000, pe_done, pe_busy, pe_enable} :
                                  32'h0000_0000;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= ack_next;
            wb_err_o <= err_next;
            wb_dat_o <= rd_next;
        end
    end

    // Prescaler: one enable in eight when selected
    logic [2:0] pre_reg;
    logic       div_tick;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pre_reg <= 3'h0;
        end else begin
            pre_reg <= (pre_reg == ncd_pkg::prescale_last) ? 3'h0 : pre_reg + 3'h1;
        end
    end
    assign div_tick = prescale_reg ? (pre_reg == ncd_pkg::prescale_last) : 1'b1;

    // Divide by field plus one; one pulse per memory clock period
    logic [ncd_pkg::div_w-1:0] div_cnt_reg;
    logic [ncd_pkg::div_w-1:0] div_cnt_next;
    logic                      div_wrap;
    logic                      mem_clk_next;
    assign div_wrap     = div_tick && (div_cnt_reg == divisor_reg);
    assign div_cnt_next = div_wrap ? '0 :
                          div_tick ? div_cnt_reg + 1'b1 :
                                     div_cnt_reg;
    // High in the upper half of the count; a zero divisor leaves it low
    assign mem_clk_next = (div_cnt_next > (divisor_reg >> 1));

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_reg        <= '0;
            nvm_internal_clock <= 1'b0;
            timing_pulse       <= 1'b0;
        end else begin
            div_cnt_reg        <= div_cnt_next;
            nvm_internal_clock <= mem_clk_next;
            timing_pulse       <= div_wrap && loaded_reg;
        end
    end

    assign pe_enable = loaded_reg;

    // Sequencer timing in whole pulses
    ncd_pkg::ncd_phase_t phase_reg;
    logic [15:0]         left_reg;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            phase_reg <= ncd_pkg::ph_idle;
            left_reg  <= 16'h0000;
            pe_done   <= 1'b0;
        end else begin
            pe_done <= 1'b0;
            case (phase_reg)
                ncd_pkg::ph_idle: begin
                    if (pe_request && loaded_reg && pe_pulse_count != 16'h0000) begin
                        phase_reg <= ncd_pkg::ph_run;
                        left_reg  <= pe_pulse_count;
                    end
                end
                ncd_pkg::ph_run: begin
                    if (timing_pulse) begin
                        if (left_reg == 16'h0001) begin
                            phase_reg <= ncd_pkg::ph_idle;
                            pe_done   <= 1'b1;
                        end
                        left_reg <= left_reg - 16'h0001;
                    end
                end
                default: phase_reg <= ncd_pkg::ph_idle;
            endcase
        end
    end
    assign pe_busy = (phase_reg == ncd_pkg::ph_run);

    // Checks
    write_once_a: assert property (@(posedge mclk) disable iff (!rst_n)
        loaded_reg |=> ($stable(prescale_reg) && $stable(divisor_reg) && loaded_reg))
        else $error("divider settings changed after load");
    first_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ctrl_wr && !loaded_reg) |=> (loaded_reg && divisor_reg == $past(wb_dat_i[ncd_pkg::div_w-1:0])))
        else $error("first write did not load divider");
    flag_reset_a: assert property (@(posedge mclk)
        !rst_n |-> (ctrl_view == ncd_pkg::ctrl_reset))
        else $error("divider register not cleared by reset");
    pe_block_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !loaded_reg |-> (!pe_busy && !timing_pulse && !pe_enable))
        else $error("erase or program allowed before load");
    read_back_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (req && hit_ctrl && !wb_we_i) |=> (wb_ack_o && wb_dat_o[7:0] == $past(ctrl_view)))
        else $error("divider register read wrong");
    prescale_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (prescale_reg && div_tick) |=> !div_tick[*7])
        else $error("prescaler ticks too often");
    divide_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (!prescale_reg && loaded_reg && divisor_reg == 6'h03 && div_wrap) |=> !div_wrap[*3] ##1 div_wrap)
        else $error("divider ratio wrong");
    pulse_len_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (timing_pulse && (prescale_reg || divisor_reg != 6'h00)) |=> !timing_pulse)
        else $error("timing pulse wider than one cycle");
    done_count_a: assert property (@(posedge mclk) disable iff (!rst_n)
        pe_done |-> $past(timing_pulse) && $past(left_reg) == 16'h0001)
        else $error("operation ended off a pulse boundary");

    // Bus answer
    ack_one_cycle_a: assert property (@(posedge mclk) disable iff (!rst_n)
        wb_ack_o
        |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    err_one_cycle_a: assert property (@(posedge mclk) disable iff (!rst_n)
        wb_err_o
        |=> !wb_err_o)
        else $error("err held longer than one cycle");
    ack_err_excl_a: assert property (@(posedge mclk) disable iff (!rst_n)
        wb_ack_o
        |-> !wb_err_o)
        else $error("ack and err together");
    ack_timing_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (req && (hit_ctrl || hit_state))
        |=> (wb_ack_o && !wb_err_o))
        else $error("mapped request not acked next cycle");
    err_unmapped_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (req && !(hit_ctrl || hit_state))
        |=> (wb_err_o && !wb_ack_o))
        else $error("unmapped request not refused");
    status_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (req && hit_state && !wb_we_i)
        |=> (wb_dat_o[2:0] == $past({pe_done, pe_busy, pe_enable})))
        else $error("status read wrong");
    upper_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
        wb_ack_o
        |-> (wb_dat_o[31:8] == 24'h00_0000))
        else $error("unused read bits not zero");

    // Divider register, then outputs at reset
    late_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ctrl_wr && loaded_reg)
        |=> (ctrl_view == $past(ctrl_view)))
        else $error("later write changed the divider register");
    prescale_load_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ctrl_wr && !loaded_reg)
        |=> (prescale_reg == $past(wb_dat_i[ncd_pkg::prescale_bit])))
        else $error("prescale bit not loaded");
    state_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (req && hit_state && wb_we_i)
        |=> $stable(ctrl_view))
        else $error("status write changed the divider register");
    outputs_reset_a: assert property (@(posedge mclk)
        !rst_n
        |-> (!wb_ack_o && !pe_busy && !pe_enable && !timing_pulse))
        else $error("outputs not cleared by reset");

    // Divider
    pre_period_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (prescale_reg && div_tick)
        |=> !div_tick[*7] ##1 div_tick)
        else $error("prescaler period not eight");
    count_range_a: assert property (@(posedge mclk) disable iff (!rst_n)
        1'b1
        |-> (div_cnt_reg <= divisor_reg))
        else $error("divider count beyond divisor");
    clock_low_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (div_wrap && divisor_reg != 6'h00)
        |=> !nvm_internal_clock)
        else $error("memory clock not low at period start");
    pulse_period_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (timing_pulse && !prescale_reg && divisor_reg == 6'h03)
        |=> !timing_pulse[*3] ##1 timing_pulse)
        else $error("timing pulse period wrong");
    pulse_load_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (div_wrap && loaded_reg)
        |=> timing_pulse)
        else $error("timing pulse missing at period end");

    // Sequencer
    start_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (pe_request && !loaded_reg)
        |=> !pe_busy)
        else $error("operation started before load");
    start_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (!pe_busy && pe_request && loaded_reg && pe_pulse_count != 16'h0000)
        |=> pe_busy)
        else $error("permitted request not taken");
    zero_count_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (!pe_busy && pe_pulse_count == 16'h0000)
        |=> !pe_busy)
        else $error("empty operation started");
    done_pulse_a: assert property (@(posedge mclk) disable iff (!rst_n)
        pe_done
        |=> !pe_done)
        else $error("done held longer than one cycle");
    done_idle_a: assert property (@(posedge mclk) disable iff (!rst_n)
        pe_done
        |-> !pe_busy)
        else $error("busy still high at done");
    left_nonzero_a: assert property (@(posedge mclk) disable iff (!rst_n)
        pe_busy
        |-> (left_reg != 16'h0000))
        else $error("busy with no pulses left");
    busy_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (pe_busy && !timing_pulse)
        |=> pe_busy)
        else $error("operation ended without a pulse");

endmodule

`default_nettype wire

// ==== src/ncd_pkg.sv ====
package ncd_pkg;
    // Register map (byte addresses on a 32-bit classic Wishbone)
    localparam logic [3:0] ctrl_addr      = 4'h0;
    localparam logic [3:0] state_addr     = 4'h4;
    localparam int         addr_w         = 4;
    // Field layout of the divider control register
    localparam int         loaded_bit     = 7;
    localparam int         prescale_bit   = 6;
    localparam int         div_w          = 6;
    localparam logic [7:0] ctrl_reset     = 8'h00;
    // Prescaler ratio
    localparam logic [2:0] prescale_last  = 3'h7;
    // Memory clock range accepted by the memory (software keeps to it)
    localparam int         mem_clk_min_khz = 150;
    localparam int         mem_clk_max_khz = 200;
    // Divider phases, one-hot
    typedef enum logic [1:0] {
        ph_idle = 2'b01,
        ph_run  = 2'b10
    } ncd_phase_t;
endpackage

// ==== tb/ncd_seq_model.sv ====
`timescale 1ns/100ps
`default_nettype none

module ncd_seq_model (
    // Clock
    input  wire logic        mclk,
    // Bench control
    input  wire logic        go,
    input  wire logic [15:0] n,
    // Divider side
    input  wire logic        pe_busy,
    input  wire logic        timing_pulse,
    output logic             pe_request,
    output logic [15:0]      pe_pulse_count,
    output var int           pulses
);
    initial begin
        pe_request = 1'b0;
        pe_pulse_count = 16'h0000;
        pulses = 0;
    end
    // Request held while go is high until busy answers; a released count inverts every cycle, so it shows the old value every other cycle
    always @(posedge mclk) begin
        pe_request <= go && !pe_busy;
        pe_pulse_count <= (go && !pe_busy) ? n : ~pe_pulse_count;
        if (go && !pe_busy && !pe_request) begin
            pulses <= 0;
        end else if (pe_busy && timing_pulse) begin
            pulses <= pulses + 1;
        end
    end
endmodule

`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/100ps
`default_nettype none

module tb;
    logic        mclk = 1'b0, nrst = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, go = 1'b0;
    logic [3:0]  adr = 4'h0;
    logic [31:0] dat = 32'h0000_0000, rd, q;
    logic [15:0] n = 16'h0000, cnt;
    logic        ack, err, req, en, mem_clk, tp, busy, done, e;
    int          pulses, failures = 0, check_count = 0, exp, i, k, d, per, nn, r, pf;
    always #20 mclk = ~mclk;
    ncd_clock_divider ncd_clock_divider_i (.mclk(mclk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack),
        .wb_err_o(err), .pe_request(req), .pe_pulse_count(cnt), .pe_enable(en),
        .nvm_internal_clock(mem_clk), .timing_pulse(tp), .pe_busy(busy), .pe_done(done));
    ncd_seq_model ncd_seq_model_i (.mclk(mclk), .go(go), .n(n), .pe_busy(busy), .timing_pulse(tp),
        .pe_request(req), .pe_pulse_count(cnt), .pulses(pulses));
    task automatic conclude;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input int x);
        check_count++;
        if (g !== 32'(x)) begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, g, x);
        end
    endtask
    task automatic tmo(input int t);
        if (t >= 2000) begin
            failures++;
            $display("[FAIL] %0t wait ran out", $time);
            conclude;
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] dd);
        int t;
        t = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= dd;
        do begin
            @(posedge mclk);
            t++;
        end while (ack !== 1'b1 && err !== 1'b1 && t < 2000);
        tmo(t);
        q = rd;
        e = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge mclk);
    endtask
    initial begin
        void'($urandom(32'h55d2));
        for (k = 0; k < 4; k++) begin
            // Last run keeps the memory clock inside its legal band at 25 MHz
            d = (k == 0) ? 0 : (k == 1) ? 3 : (k == 2) ? 64 + $urandom % 4 : 79 + $urandom % 5;
            nrst <= 1'b0;
            repeat (10) @(posedge mclk);
            nrst <= 1'b1;
            repeat (3) @(posedge mclk);
            exp = 0;
            wb(1'b0, ncd_pkg::ctrl_addr, 32'h0000_0000);
            chk(q, exp);
            n <= 16'h0002;
            go <= 1'b1;
            repeat (40) @(posedge mclk);
            chk({31'h0000_0000, busy}, 0);
            chk(32'(pulses), 0);
            go <= 1'b0;
            wb(1'b1, ncd_pkg::ctrl_addr, 32'h0000_ff00 | 32'(d));
            exp = 128 + d;
            wb(1'b0, ncd_pkg::ctrl_addr, 32'h0000_0000);
            chk(q, exp);
            wb(1'b1, ncd_pkg::ctrl_addr, 32'(~d & 127));
            wb(1'b0, ncd_pkg::ctrl_addr, 32'h0000_0000);
            chk(q, exp);
            wb(1'b0, ncd_pkg::state_addr, 32'h0000_0000);
            chk({31'h0000_0000, q[0] & en}, 1);
            per = (d % 64 + 1) * (d >= 64 ? 8 : 1);
            for (i = 0; i < 2000 && tp !== 1'b1; i++) @(posedge mclk);
            tmo(i);
            i = 0;
            r = 0;
            pf = mem_clk;
            do begin
                @(posedge mclk);
                i++;
                r += (mem_clk && !pf) ? 1 : 0;
                pf = mem_clk;
            end while (tp !== 1'b1 && i < 2000);
            chk(32'(i), per);
            chk(32'(r), (d % 64 != 0) ? 1 : 0);
            nn = 1 + $urandom % 3;
            n <= 16'(nn);
            go <= 1'b1;
            for (i = 0; i < 2000 && busy !== 1'b1; i++) @(posedge mclk);
            tmo(i);
            go <= 1'b0;
            for (i = 0; i < 2000 && done !== 1'b1; i++) @(posedge mclk);
            tmo(i);
            chk(32'(pulses), nn);
            wb(1'b0, 4'hc, 32'h0000_0000);
            chk({31'h0000_0000, e}, 1);
            $display("test %0d done", k);
        end
        conclude;
    end
endmodule

`default_nettype wire
